// *** src/sclgm_pkg.sv ***
/*
  Shared constants for the scan-list channel/gain memory: register map,
  entry field layout, list geometry and bus response codes.
  Assumes a 32-bit AXI4-Lite register bus and one clock domain.
*/
package sclgm_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_ENTRY   = 8'h00;  // Write only: next list entry
  localparam logic [7:0] ADDR_CONTROL = 8'h04;  // Write only: strobes
  localparam logic [7:0] ADDR_CONFIG  = 8'h08;  // Read/write: mode bits
  localparam logic [7:0] ADDR_STATUS  = 8'h0C;  // Read only

  // ---------------------------------------------------------------
  // Control strobe bits and config bits
  // ---------------------------------------------------------------
  localparam int CTRL_LIST_CLEAR = 0;
  localparam int CTRL_LIST_LOAD  = 1;
  localparam int CTRL_CONV_CLEAR = 2;
  localparam int CFG_DIFFERENTIAL = 0;
  localparam int CFG_COUNT_SRC4   = 1;
  localparam logic [1:0] CONFIG_RESET = 2'h0;

  // ---------------------------------------------------------------
  // Status layout
  // ---------------------------------------------------------------
  localparam int STAT_FULL_N   = 0;
  localparam int STAT_LOADED   = 1;
  localparam int STAT_RDPTR_LO = 4;
  localparam int STAT_COUNT_LO = 16;

  // ---------------------------------------------------------------
  // Entry field layout
  // ---------------------------------------------------------------
  localparam int ENTRY_W     = 9;
  localparam int EOS_BIT     = 0;
  localparam int GAIN_LO     = 1;
  localparam int GAIN_HI     = 3;
  localparam int MUX_LO      = 4;
  localparam int MUX_HI      = 7;
  localparam int SKIP_BIT    = 8;
  localparam logic [3:0] DIFF_NEG_OFFSET = 4'h8;

  // ---------------------------------------------------------------
  // List geometry
  // ---------------------------------------------------------------
  localparam int LIST_DEPTH = 512;
  localparam int PTR_W      = 9;
  localparam int CNT_W      = 10;
  localparam logic [CNT_W-1:0] LIST_FULL_COUNT = 10'h200;

  // ---------------------------------------------------------------
  // Bus responses
  // ---------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** src/sclgm_decode.sv ***
/*
  Entry decoder: splits one stored entry into multiplexer, gain and flag
  settings, honouring single-ended or differential channel selection.
  Purely combinational; the caller registers the results.
*/
`timescale 1ns/10ps
module sclgm_decode (
  input  wire logic [sclgm_pkg::ENTRY_W-1:0] entry,     // Stored entry
  input  wire logic                          diff_mode, // Differential select
  output logic      [3:0]                    mux_pos,   // Positive channel
  output logic      [3:0]                    mux_neg,   // Negative channel
  output logic                               neg_used,  // Negative in use
  output logic      [2:0]                    gain_code, // Gain code
  output logic                               skip,      // Skip-store flag
  output logic                               eos        // End-of-sequence
);

  logic [3:0] mux_channel_field;

  always_comb begin
    mux_channel_field = entry[sclgm_pkg::MUX_HI:sclgm_pkg::MUX_LO];
    gain_code         = entry[sclgm_pkg::GAIN_HI:sclgm_pkg::GAIN_LO];
    skip              = entry[sclgm_pkg::SKIP_BIT];
    eos               = entry[sclgm_pkg::EOS_BIT];
    neg_used          = diff_mode;
    if (diff_mode) begin
      mux_pos = {1'b0, mux_channel_field[2:0]};
      mux_neg = mux_pos + sclgm_pkg::DIFF_NEG_OFFSET;
    end else begin
      mux_pos = mux_channel_field;
      mux_neg = 4'h0;
    end
  end

endmodule // sclgm_decode

// *** src/sclgm_top.sv ***
/*
  Scan-list channel/gain memory behind AXI4-Lite: 512 entries, stepped per conversion.
  Assumes synchronous triggers and a result FIFO and sample counter fed by its pulses.
*/
// Design decisions made here: the AXI4-Lite register port and the address map.
`timescale 1ns/10ps
// Summary of operation
// - Skip-store entries convert, but no result store pulse is given.
// - When counting source 4, skip-store conversions give no count pulse.
// - Entries without skip-store give a normal stored conversion.
// - Entry bits 7..4 drive the multiplexer address.
// - Single-ended mode selects the one channel equal to the field.
// - Differential selects low three bits n and n+8; top bit ignored.
// - Entry bits 3..1 select gains 0.5,1,2,5,10,20,50,100.
// - Several end-of-sequence entries may coexist; stepping does not stop.
// - After clear each entry write lands at the next position.
// - Active-low full flag in status; host stops writing when full.
// - List load presents the first entry on the outputs.
// - Each conversion, external or counter 3, steps to the next entry.
// - Stepping past the last stored entry wraps to the first.
// - Conversion clear returns to the first entry, keeping entries.
// - The list holds up to 512 entries.
// - List clear discards all entries and empties the list.
module sclgm_top (
  input  wire logic        aclk,               // Clock, 40 MHz
  input  wire logic        aresetn,            // Sync reset, active low
  input  wire logic [7:0]  s_axi_awaddr,       // Write address
  input  wire logic        s_axi_awvalid,      // Write address valid
  output logic             s_axi_awready,      // Write address ready
  input  wire logic [31:0] s_axi_wdata,        // Write data
  input  wire logic [3:0]  s_axi_wstrb,        // Write byte strobes
  input  wire logic        s_axi_wvalid,       // Write data valid
  output logic             s_axi_wready,       // Write data ready
  output logic [1:0]       s_axi_bresp,        // Write response
  output logic             s_axi_bvalid,       // Write response valid
  input  wire logic        s_axi_bready,       // Write response ready
  input  wire logic [7:0]  s_axi_araddr,       // Read address
  input  wire logic        s_axi_arvalid,      // Read address valid
  output logic             s_axi_arready,      // Read address ready
  output logic [31:0]      s_axi_rdata,        // Read data
  output logic [1:0]       s_axi_rresp,        // Read response
  output logic             s_axi_rvalid,       // Read data valid
  input  wire logic        s_axi_rready,       // Read data ready
  input  wire logic        external_convert_n, // Convert trigger, active low
  input  wire logic        counter3_convert,   // Counter 3 trigger pulse
  output logic [3:0]       mux_pos,            // Positive channel select
  output logic [3:0]       mux_neg,            // Negative channel select
  output logic             mux_neg_used,       // Differential pair active
  output logic [2:0]       gain_code,          // Amplifier gain code
  output logic             end_of_sequence_flag, // Current entry ends sequence
  output logic             conversion_start,   // Pulse: conversion begins
  output logic             result_store,       // Pulse: store result in FIFO
  output logic             sample_count        // Pulse: count this sample
);

  // ---------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------
  logic [7:0]  aw_addr, next_aw_addr;
  logic        aw_got, next_aw_got;
  logic [31:0] w_data, next_w_data;
  logic [3:0]  w_strb, next_w_strb;
  logic        w_got, next_w_got;
  logic        next_awready, next_wready, next_bvalid, next_arready, next_rvalid, wr_go;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic [31:0] status_word;
  logic [1:0]  config_bits, next_config_bits;

  // List state
  logic [sclgm_pkg::ENTRY_W-1:0] mem [sclgm_pkg::LIST_DEPTH];
  logic [sclgm_pkg::ENTRY_W-1:0] next_mem [sclgm_pkg::LIST_DEPTH];
  logic [sclgm_pkg::CNT_W-1:0]   wr_count, next_wr_count;
  logic [sclgm_pkg::PTR_W-1:0]   rd_ptr, next_rd_ptr;
  logic                          loaded, next_loaded;
  logic                          list_full_n, next_list_full_n;
  logic                          ext_prev, next_ext_prev;
  logic                          cur_skip, next_cur_skip;
  logic                          next_conversion_start, next_result_store, next_sample_count;
  logic [3:0]                    next_mux_pos, next_mux_neg;
  logic                          next_mux_neg_used, next_eos;
  logic [2:0]                    next_gain_code;
  logic                          conv_fire, at_last, entry_wr, ctrl_wr;
  logic                          list_clear_strobe, list_load_strobe, conversion_clear_strobe;
  logic [sclgm_pkg::PTR_W-1:0]   show_ptr;
  assign wr_go       = aw_got && w_got && !s_axi_bvalid;
  assign status_word = {6'h00, wr_count, 3'h0, rd_ptr, 2'h0, loaded, list_full_n};
  always_comb begin
    next_aw_addr     = aw_addr;
    next_aw_got      = aw_got;
    next_w_data      = w_data;
    next_w_strb      = w_strb;
    next_w_got       = w_got;
    next_bvalid      = s_axi_bvalid;
    next_bresp       = s_axi_bresp;
    next_rvalid      = s_axi_rvalid;
    next_rdata       = s_axi_rdata;
    next_rresp       = s_axi_rresp;
    next_config_bits = config_bits;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_addr = s_axi_awaddr;
      next_aw_got  = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
      next_w_got  = 1'b1;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (wr_go) begin
      next_aw_got = 1'b0;
      next_w_got  = 1'b0;
      next_bvalid = 1'b1;
      next_bresp  = sclgm_pkg::RESP_OKAY;
      unique case (aw_addr)
        sclgm_pkg::ADDR_ENTRY, sclgm_pkg::ADDR_CONTROL, sclgm_pkg::ADDR_STATUS: ;
        sclgm_pkg::ADDR_CONFIG: next_config_bits = w_strb[0] ? w_data[1:0] : config_bits;
        default: next_bresp = sclgm_pkg::RESP_SLVERR;
      endcase
    end
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = sclgm_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        sclgm_pkg::ADDR_ENTRY, sclgm_pkg::ADDR_CONTROL: next_rdata = 32'h00000000;
        sclgm_pkg::ADDR_CONFIG: next_rdata = {30'h00000000, config_bits};
        sclgm_pkg::ADDR_STATUS: next_rdata = status_word;
        default: begin
          next_rdata = 32'h00000000;
          next_rresp = sclgm_pkg::RESP_SLVERR;
        end
      endcase
    end
    next_awready = !next_aw_got && !next_bvalid;
    next_wready  = !next_w_got && !next_bvalid;
    next_arready = !next_rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr       <= 8'h00;
      aw_got        <= 1'b0;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
      w_got         <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= sclgm_pkg::RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= sclgm_pkg::RESP_OKAY;
      config_bits   <= sclgm_pkg::CONFIG_RESET;
    end else begin
      aw_addr       <= next_aw_addr;
      aw_got        <= next_aw_got;
      w_data        <= next_w_data;
      w_strb        <= next_w_strb;
      w_got         <= next_w_got;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
      config_bits   <= next_config_bits;
    end
  end

  // ---------------------------------------------------------------
  // Scan list and channel outputs
  // ---------------------------------------------------------------
  assign entry_wr = wr_go && aw_addr == sclgm_pkg::ADDR_ENTRY && (&w_strb[1:0]);
  assign ctrl_wr  = wr_go && aw_addr == sclgm_pkg::ADDR_CONTROL && w_strb[0];
  assign list_clear_strobe       = ctrl_wr && w_data[sclgm_pkg::CTRL_LIST_CLEAR];
  assign list_load_strobe        = ctrl_wr && w_data[sclgm_pkg::CTRL_LIST_LOAD];
  assign conversion_clear_strobe = ctrl_wr && w_data[sclgm_pkg::CTRL_CONV_CLEAR];
  assign conv_fire = loaded && !ctrl_wr
                   && ((ext_prev && !external_convert_n) || counter3_convert);
  assign at_last   = ({1'b0, rd_ptr} + 10'h001) >= wr_count;
  sclgm_decode u_decode (
    .entry     (mem[show_ptr]),
    .diff_mode (config_bits[sclgm_pkg::CFG_DIFFERENTIAL]),
    .mux_pos   (next_mux_pos),
    .mux_neg   (next_mux_neg),
    .neg_used  (next_mux_neg_used),
    .gain_code (next_gain_code),
    .skip      (next_cur_skip),
    .eos       (next_eos)
  );
  always_comb begin
    next_mem              = mem;
    next_wr_count         = wr_count;
    next_rd_ptr           = rd_ptr;
    next_loaded           = loaded;
    next_ext_prev         = external_convert_n;
    next_conversion_start = 1'b0;
    next_result_store     = 1'b0;
    next_sample_count     = 1'b0;
    show_ptr              = rd_ptr;
    if (list_clear_strobe) begin
      for (int i = 0; i < sclgm_pkg::LIST_DEPTH; i++) begin
        next_mem[i] = '0;
      end
      next_wr_count = '0;
      next_rd_ptr   = '0;
      next_loaded   = 1'b0;
    end else if (conversion_clear_strobe) begin
      next_rd_ptr = '0;
      next_loaded = list_load_strobe && wr_count != '0;
    end else if (list_load_strobe) begin
      next_rd_ptr = '0;
      next_loaded = wr_count != '0;
    end
    if (entry_wr && list_full_n && !list_clear_strobe) begin
      next_mem[wr_count[sclgm_pkg::PTR_W-1:0]] = w_data[sclgm_pkg::ENTRY_W-1:0];
      next_wr_count = wr_count + 10'h001;
    end
    if (conv_fire) begin
      next_conversion_start = 1'b1;
      next_result_store     = !cur_skip;
      next_sample_count     = !(cur_skip && config_bits[sclgm_pkg::CFG_COUNT_SRC4]);
      next_rd_ptr = at_last ? '0 : rd_ptr + 9'h001;
    end
    show_ptr         = next_rd_ptr;
    next_list_full_n = next_wr_count != sclgm_pkg::LIST_FULL_COUNT;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < sclgm_pkg::LIST_DEPTH; i++) begin
        mem[i] <= '0;
      end
      wr_count             <= '0;
      rd_ptr               <= '0;
      loaded               <= 1'b0;
      list_full_n          <= 1'b1;
      ext_prev             <= 1'b1;
      cur_skip             <= 1'b0;
      conversion_start     <= 1'b0;
      result_store         <= 1'b0;
      sample_count         <= 1'b0;
      mux_pos              <= 4'h0;
      mux_neg              <= 4'h0;
      mux_neg_used         <= 1'b0;
      gain_code            <= 3'h0;
      end_of_sequence_flag <= 1'b0;
    end else begin
      mem                  <= next_mem;
      wr_count             <= next_wr_count;
      rd_ptr               <= next_rd_ptr;
      loaded               <= next_loaded;
      list_full_n          <= next_list_full_n;
      ext_prev             <= next_ext_prev;
      conversion_start     <= next_conversion_start;
      result_store         <= next_result_store;
      sample_count         <= next_sample_count;
      if (next_loaded) begin
        cur_skip             <= next_cur_skip;
        mux_pos              <= next_mux_pos;
        mux_neg              <= next_mux_neg;
        mux_neg_used         <= next_mux_neg_used;
        gain_code            <= next_gain_code;
        end_of_sequence_flag <= next_eos;
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_skip_no_store;
    conv_fire && cur_skip |=> conversion_start && !result_store;
  endproperty
  a_skip_no_store: assert property (p_skip_no_store) else $error("skip entry stored");
  property p_count_src4;
    conv_fire && cur_skip && config_bits[sclgm_pkg::CFG_COUNT_SRC4] |=> !sample_count;
  endproperty
  a_count_src4: assert property (p_count_src4) else $error("skip entry counted");
  property p_normal_store;
    conv_fire && !cur_skip |=> result_store && sample_count;
  endproperty
  a_normal_store: assert property (p_normal_store) else $error("normal not stored");
  property p_load_first;
    list_load_strobe && !list_clear_strobe && !conversion_clear_strobe && wr_count != '0
      |=> loaded && rd_ptr == '0 && gain_code == $past(mem[0][3:1]);
  endproperty
  a_load_first: assert property (p_load_first) else $error("load wrong entry");
  property p_single_ended;
    loaded && !config_bits[sclgm_pkg::CFG_DIFFERENTIAL] && !mux_neg_used && $stable(config_bits)
      && $stable(rd_ptr) && $stable(loaded) |-> mux_pos == mem[rd_ptr][7:4];
  endproperty
  a_single_ended: assert property (p_single_ended) else $error("bad channel");
  property p_diff_pair;
    mux_neg_used |-> mux_neg == mux_pos + 4'h8 && !mux_pos[3];
  endproperty
  a_diff_pair: assert property (p_diff_pair) else $error("bad pair");
  property p_write_seq;
    entry_wr && list_full_n && !list_clear_strobe |=> wr_count == $past(wr_count) + 10'h001;
  endproperty
  a_write_seq: assert property (p_write_seq) else $error("write not sequential");
  property p_full_flag;
    list_full_n == (wr_count != sclgm_pkg::LIST_FULL_COUNT) && wr_count <= 10'h200;
  endproperty
  a_full_flag: assert property (p_full_flag) else $error("full flag wrong");
  property p_step;
    conv_fire |=> rd_ptr == ($past(at_last) ? 9'h000 : $past(rd_ptr) + 9'h001);
  endproperty
  a_step: assert property (p_step) else $error("pointer step wrong");
  property p_conv_clear;
    conversion_clear_strobe && !list_clear_strobe && !list_load_strobe
      |=> rd_ptr == '0 && wr_count >= $past(wr_count) && !loaded ##1 !conversion_start;
  endproperty
  a_conv_clear: assert property (p_conv_clear) else $error("conv clear wrong");
  property p_list_clear;
    list_clear_strobe |=> wr_count == '0 && list_full_n && !loaded && mem[0] == '0;
  endproperty
  a_list_clear: assert property (p_list_clear) else $error("clear incomplete");

  c_wrap: cover property (conv_fire && at_last && wr_count > 10'h001);
  c_skip: cover property (conv_fire && cur_skip);
  c_full: cover property (!list_full_n);

endmodule // sclgm_top

// *** verif/sclgm_analog_model.sv ***
/*
  Stand-in for the gain amplifier, with a count of conversion start pulses.
  Assumes the scan-list outputs of sclgm_top on the same clock.
*/
`timescale 1ns/10ps
module sclgm_analog_model (
  input  wire logic       aclk,      // Clock
  input  wire logic       aresetn,   // Sync reset, active low
  input  wire logic [2:0] gain_code, // Amplifier gain code
  input  wire logic       conv,      // Conversion start pulse
  output logic      [9:0] gain_x10,  // Gain times ten
  output logic      [9:0] conv_seen  // Conversions seen
);
  localparam logic [9:0] GAIN_TAB [8] = '{10'h005, 10'h00A, 10'h014, 10'h032,
                                          10'h064, 10'h0C8, 10'h1F4, 10'h3E8};
  logic [9:0] next_conv_seen;
  assign gain_x10 = GAIN_TAB[gain_code];
  always_comb begin
    next_conv_seen = conv ? conv_seen + 10'h001 : conv_seen;
  end
  always_ff @(posedge aclk) begin
    conv_seen <= aresetn ? next_conv_seen : 10'h000;
  end
endmodule // sclgm_analog_model

// *** verif/testbench.sv ***
/*
  Self-checking bench for sclgm_top: bus tasks, triggers, scenarios.
  Assumes the register map and entry layout of sclgm_pkg.
*/
`timescale 1ns/10ps
module testbench;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arvalid, s_axi_arready, s_axi_rvalid, ext_n, c3;
  logic        mux_neg_used, eos, conv, store, count, st, ct, seen;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  mux_pos, mux_neg;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [2:0]  gain_code;
  logic [9:0]  gain_x10, conv_seen;
  int          err_count, compares;
  localparam logic [9:0] GX [8] = '{10'h005, 10'h00A, 10'h014, 10'h032,
                                    10'h064, 10'h0C8, 10'h1F4, 10'h3E8};
  sclgm_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready(1'b1), .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'b1),
    .external_convert_n(ext_n), .counter3_convert(c3), .mux_pos, .mux_neg, .mux_neg_used,
    .gain_code, .end_of_sequence_flag(eos), .conversion_start(conv),
    .result_store(store), .sample_count(count));
  sclgm_analog_model afe (.aclk, .aresetn, .gain_code, .conv, .gain_x10, .conv_seen);
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  task automatic complete_run();
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [9:0] seen_v, input logic [9:0] exp_v);
    compares++;
    if (seen_v !== exp_v) begin
      err_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen_v, exp_v);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && s_axi_awready === 1'b1) begin aw = 1'b1; s_axi_awvalid <= 1'b0; end
      if (!w && s_axi_wready === 1'b1) begin w = 1'b1; s_axi_wvalid <= 1'b0; end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
  endtask
  task automatic rdr(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
  endtask
  task automatic ctl(input int b);
    wr(sclgm_pkg::ADDR_CONTROL, 32'(1 << b));
  endtask
  // Falling edge on the external input or one counter 3 pulse
  task automatic trig(input bit ext);
    if (ext) ext_n <= 1'b0;
    else c3 <= 1'b1;
    @(posedge aclk);
    ext_n <= 1'b1;
    c3 <= 1'b0;
    seen = 1'b0;
    for (int k = 0; k < 4 && !seen; k++) begin
      @(posedge aclk);
      if (conv === 1'b1) begin seen = 1'b1; st = store; ct = count; end
    end
  endtask
  task automatic show(input int i, input bit diff);
    logic [3:0] m;
    m = 4'(2 * i + 1);
    chk(10'(mux_pos), diff ? {7'h0, m[2:0]} : 10'(m));
    chk(10'(mux_neg), diff ? {6'h0, 1'b1, m[2:0]} : 10'h000);
    chk(10'({mux_neg_used, gain_code}), 10'({diff, 3'(i)}));
    chk(gain_x10, GX[i]);
    chk(10'(eos), 10'(i % 4 == 3));
  endtask
  task automatic t_reset();
    rdr(sclgm_pkg::ADDR_STATUS);
    chk(rd[25:16], 10'h000); chk(10'(rd[1:0]), 10'h001);
    rdr(8'h10);
    chk(10'(rs), 10'(sclgm_pkg::RESP_SLVERR));
    wr(8'h10, 32'h0000_0001);
    chk(10'(rs), 10'(sclgm_pkg::RESP_SLVERR));
    trig(1'b0);
    chk(10'(seen), 10'h000);
  endtask
  task automatic t_scan(input bit diff);
    wr(sclgm_pkg::ADDR_CONFIG, {30'h0, diff, diff});
    ctl(sclgm_pkg::CTRL_LIST_CLEAR);
    for (int i = 0; i < 8; i++) begin
      wr(sclgm_pkg::ADDR_ENTRY, {23'h0, i[0], 4'(2 * i + 1), 3'(i), i % 4 == 3});
    end
    rdr(sclgm_pkg::ADDR_STATUS);
    chk(rd[25:16], 10'h008);
    ctl(sclgm_pkg::CTRL_LIST_LOAD);
    show(0, diff);
    for (int i = 1; i <= 8; i++) begin
      trig(i[0]);
      chk(10'(seen), 10'h001);
      // Pulses belong to entry i-1; odd entries skip
      chk(10'(st), 10'(i[0]));
      chk(10'(ct), 10'(i[0] || !diff));
      show(i % 8, diff);
    end
  endtask
  task automatic t_conv_clear();
    trig(1'b1);
    ctl(sclgm_pkg::CTRL_CONV_CLEAR);
    trig(1'b0);
    chk(10'(seen), 10'h000);
    ctl(sclgm_pkg::CTRL_LIST_LOAD);
    show(0, 1'b1);
    rdr(sclgm_pkg::ADDR_STATUS);
    chk(rd[25:16], 10'h008);
    chk(10'(rd[12:4]), 10'h000);
  endtask
  task automatic t_full();
    ctl(sclgm_pkg::CTRL_LIST_CLEAR);
    repeat (513) wr(sclgm_pkg::ADDR_ENTRY, 32'h0000_0010);
    chk(10'(rs), 10'(sclgm_pkg::RESP_OKAY));
    rdr(sclgm_pkg::ADDR_STATUS);
    chk(10'(rd[0]), 10'h000); chk(rd[25:16], 10'h200);
    ctl(sclgm_pkg::CTRL_LIST_CLEAR);
    rdr(sclgm_pkg::ADDR_STATUS);
    chk(10'(rd[0]), 10'h001); chk(rd[25:16], 10'h000);
  endtask
  initial begin
    #(20000 * 25);
    err_count++;
    complete_run();
  end
  initial begin
    err_count = 0; compares = 0; aresetn = 1'b0; ext_n = 1'b1; c3 = 1'b0;
    s_axi_awvalid = 1'b0; s_axi_wvalid = 1'b0; s_axi_arvalid = 1'b0;
    s_axi_awaddr = 8'h00; s_axi_araddr = 8'h00; s_axi_wdata = 32'h0000_0000;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_scan(1'b0);
    t_scan(1'b1);
    t_conv_clear();
    chk(conv_seen, 10'h011);
    t_full();
    complete_run();
  end
endmodule // testbench
